/* srap_fifo.sv */
/*
  srap_fifo: synchronous fifo, parameterised width and depth, valid/ready both sides.
  assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module srap_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= (PW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      count <= (PW+1)'(count - 1'b1);
    end
  end
endmodule

/* srap_pkg.sv */
/*
  srap_pkg: constants and types shared by the subchannel request/address port.
  assumes one 25 MHz clock; machine cycle is divided into time slots t0..t8.
*/
package srap_pkg;
  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned FUNC_W      = 3;
  localparam int unsigned DESC_W      = ADDR_W + FUNC_W;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned WCNT_W      = 15;
  // ------------------------------------------------------------------
  // machine timing
  // ------------------------------------------------------------------
  localparam int unsigned SLOT_NS     = 80;
  localparam int unsigned CLK_NS      = 40;
  localparam int unsigned SLOT_CYC    = (SLOT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SLOTS       = 9;
  localparam logic [3:0]  SLOT_FIRST  = 4'h0;
  localparam logic [3:0]  SLOT_LAST   = 4'h8;
  localparam logic [3:0]  SLOT_ACCEPT = 4'h4;
  localparam logic [3:0]  SLOT_LATE   = 4'h8;
  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [WCNT_W-1:0] WCNT_RST = 15'h0000;

  typedef enum logic [1:0] {
    SRAP_IDLE   = 2'b00,
    SRAP_WINDOW = 2'b01,
    SRAP_ACCEPT = 2'b11,
    SRAP_HALT   = 2'b10
  } srap_state_t;
endpackage

/* srap_port.sv */
/*
  srap_port: channel side of a data subchannel's request/address connector.
  the external unit drives address, function code and an active-low request;
  this block opens a select window, accepts the descriptor, paces by machine
  time slots and queues accepted descriptors into a fifo toward memory access.
  assumes all inputs synchronous to ref_clk; memory side drains the fifo.
*/
// Operation
// - continuous window; address changes after acceptance
// - active-low request, interlocked or held
// - request present at late pulse starts another
// - interlace mode stops at zero count
// - accepted signalled only within select window
// - late timing pulse spans t0 to t8
`timescale 1ns/1ps
module srap_port
  import srap_pkg::*;
#(
  parameter int unsigned AW    = ADDR_W,
  parameter int unsigned FW    = FUNC_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [AW-1:0]     req_addr,
  input  wire logic [FW-1:0]     func_code,
  input  wire logic              xfer_req_n,
  input  wire logic              halt_req_n,
  input  wire logic              interlace_mode,
  input  wire logic              wcnt_load,
  input  wire logic [WCNT_W-1:0] wcnt_value,
  output logic                   select_window,
  output logic                   addr_accepted,
  output logic                   late_timing_pulse,
  output logic                   request_interlock,
  output logic                   halt_detect_flag,
  output logic                   zero_count,
  output logic [WCNT_W-1:0]      word_count,
  output logic [AW+FW-1:0]       desc_data,
  output logic                   desc_valid,
  input  wire logic              desc_ready
);
  // ------------------------------------------------------------------
  // machine timing
  // ------------------------------------------------------------------
  logic [3:0]  slot;
  logic [1:0]  sub;
  logic        slot_tick;
  logic        cycle_end;
  logic        accept_tick;

  assign slot_tick = (sub == 2'(SLOT_CYC - 1));
  assign cycle_end = slot_tick && (slot == SLOT_LAST);
  // accept decision sits at the end of slot 4, mid-cycle
  assign accept_tick = slot_tick && (slot == SLOT_ACCEPT);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sub <= '0;
    end else begin
      sub <= slot_tick ? '0 : 2'(sub + 1'b1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slot <= SLOT_FIRST;
    end else if (slot_tick) begin
      slot <= (slot == SLOT_LAST) ? SLOT_FIRST : 4'(slot + 1'b1);
    end
  end

  // late pulse t0..t8
  // every slot of the cycle counts, so the pulse covers the whole cycle
  // except the first sub-slot of t0, one clock after the boundary
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      late_timing_pulse <= 1'b0;
    end else begin
      late_timing_pulse <= !cycle_end;
    end
  end

  // ------------------------------------------------------------------
  // request sequencing
  // ------------------------------------------------------------------
  srap_state_t state;
  srap_state_t next_state;
  logic        fifo_ready;
  logic        take;
  logic        stop_now;
  logic        halt_seen;
  logic        last_word;
  logic [AW+FW-1:0] desc_in;

  // zero count also blocks new windows in interlace mode
  // interlace stops at zero
  assign stop_now = halt_seen || (interlace_mode && zero_count);

  assign last_word = interlace_mode && (word_count == WCNT_W'(1));
  // one push per served cycle, so address and code land together
  // request sampled at late slot
  assign take = (state == SRAP_ACCEPT) && cycle_end;

  always_comb begin
    next_state = state;
    case (state)
      SRAP_IDLE: begin
        if (!xfer_req_n && !stop_now && cycle_end) begin
          next_state = SRAP_WINDOW;
        end
      end
      SRAP_WINDOW: begin
        // fifo full holds the window open: back-pressure to the unit
        if (accept_tick && fifo_ready) begin
          next_state = SRAP_ACCEPT;
        end
      end
      SRAP_ACCEPT: begin
        if (cycle_end) begin
          // window stays open back to back
          if (!xfer_req_n && !stop_now && !last_word) begin
            next_state = SRAP_WINDOW;
          end else begin
            next_state = SRAP_IDLE;
          end
        end
      end
      SRAP_HALT: begin
        // only reset leaves halt
        next_state = SRAP_HALT;
      end
      default: begin
        next_state = SRAP_IDLE;
      end
    endcase
    if (halt_seen && state != SRAP_ACCEPT) begin
      next_state = SRAP_HALT;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= SRAP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign select_window     = (state == SRAP_WINDOW) || (state == SRAP_ACCEPT);
  assign addr_accepted     = (state == SRAP_ACCEPT);
  assign request_interlock = addr_accepted;

  assign desc_in = {func_code, req_addr};

  // ------------------------------------------------------------------
  // halt and word count
  // ------------------------------------------------------------------
  // halt latched until reset
  // the unit may release its halt request once the flag shows
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      halt_seen <= 1'b0;
    end else if (!halt_req_n) begin
      halt_seen <= 1'b1;
    end
  end

  // an accepted word finishes before the flag shows
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      halt_detect_flag <= 1'b0;
    end else begin
      halt_detect_flag <= halt_seen && (state != SRAP_ACCEPT);
    end
  end

  // a load wins over a take in the same clock
  // count down per accepted word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_count <= WCNT_RST;
    end else if (wcnt_load) begin
      word_count <= wcnt_value;
    end else if (take && word_count != '0) begin
      word_count <= WCNT_W'(word_count - 1'b1);
    end
  end

  assign zero_count = (word_count == '0);

  // ------------------------------------------------------------------
  // descriptor queue
  // ------------------------------------------------------------------
  // a full fifo stalls the window; the unit keeps its address
  // one push per window-and-accepted
  srap_fifo #(
    .WIDTH (AW + FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (desc_in),
    .in_valid  (take),
    .in_ready  (fifo_ready),
    .out_data  (desc_data),
    .out_valid (desc_valid),
    .out_ready (desc_ready)
  );
endmodule

/* srap_port_bench.sv */
/*
  srap_port_bench: self-checking bench for srap_port.
  assumes srap_unit_model as requester; memory side drained here.
*/
`timescale 1ns/1ps
module srap_port_bench;
  logic        ref_clk = 1'b0, rst = 1'b1, start = 1'b0, held = 1'b1;
  logic        halt_req_n = 1'b1, interlace_mode = 1'b0, wcnt_load = 1'b0, desc_ready = 1'b0;
  logic [14:0] wcnt_value = 15'h0000, base = 15'h0000, req_addr, word_count;
  logic [7:0]  n_words = 8'h00;
  logic [2:0]  func = 3'h0, func_code;
  logic        xfer_req_n, select_window, addr_accepted, late_timing_pulse;
  logic        request_interlock, halt_detect_flag, zero_count, desc_valid;
  logic [17:0] desc_data;
  logic [17:0] got[$];
  int          n_errors = 0, n_compared = 0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (!rst && desc_valid && desc_ready) got.push_back(desc_data);
  srap_port i_srap_port (.ref_clk, .rst, .req_addr, .func_code, .xfer_req_n, .halt_req_n,
    .interlace_mode, .wcnt_load, .wcnt_value, .select_window, .addr_accepted,
    .late_timing_pulse, .request_interlock, .halt_detect_flag, .zero_count, .word_count,
    .desc_data, .desc_valid, .desc_ready);
  srap_unit_model i_srap_unit_model (.ref_clk, .rst, .start, .held, .n_words,
    .base_addr(base), .func, .select_window, .addr_accepted, .req_addr, .func_code,
    .xfer_req_n);
  task automatic chk(string what, logic [17:0] seen, logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic go(logic [7:0] n, logic [14:0] a, logic [2:0] f, logic h);
    n_words <= n; base <= a; func <= f; held <= h; start <= 1'b1;
    cyc(1);
    start <= 1'b0;
  endtask
  task automatic load(logic [14:0] v);
    wcnt_value <= v; wcnt_load <= 1'b1; got.delete();
    cyc(1);
    wcnt_load <= 1'b0;
  endtask
  task automatic idle;
    cyc(1);
    for (int i = 0; i < 900 && !(xfer_req_n && !select_window && !desc_valid); i++) cyc(1);
  endtask
  task automatic chk_got(int n, logic [14:0] a, logic [2:0] f);
    chk("count", 18'(got.size()), 18'(n));
    foreach (got[i]) chk("desc", got[i], {f, a + 15'(i)});
  endtask
  // fifo fills while memory stalls; address wraps at the top
  task automatic t_fill_drain;
    load(15'h000c);
    go(8'd10, 15'h7ffc, 3'h5, 1'b1);
    cyc(200);
    chk("stall valid", 18'(desc_valid), 18'h1);
    chk("stall window", 18'(select_window), 18'h1);
    chk("stall accept", 18'(addr_accepted), 18'h0);
    desc_ready <= 1'b1;
    idle;
    chk_got(10, 15'h7ffc, 3'h5);
    chk("count left", 18'(word_count), 18'h2);
  endtask
  task automatic t_interlock;
    load(15'h0009);
    go(8'd3, 15'h0001, 3'h2, 1'b0);
    idle;
    chk_got(3, 15'h0001, 3'h2);
  endtask
  task automatic t_interlace;
    interlace_mode <= 1'b1;
    load(15'h0002);
    go(8'd5, 15'h0100, 3'h7, 1'b1);
    for (int i = 0; i < 900 && !(zero_count && !select_window); i++) cyc(1);
    cyc(40);
    chk_got(2, 15'h0100, 3'h7);
    chk("zero", 18'(zero_count), 18'h1);
    go(8'd0, 15'h0000, 3'h0, 1'b1);
    interlace_mode <= 1'b0;
  endtask
  // halt is sticky, so it runs last
  task automatic t_halt;
    halt_req_n <= 1'b0;
    for (int i = 0; i < 200 && !halt_detect_flag; i++) cyc(1);
    halt_req_n <= 1'b1;
    load(15'h0004);
    go(8'd2, 15'h0020, 3'h1, 1'b1);
    cyc(60);
    chk("halted count", 18'(got.size()), 18'h0);
    chk("halt flag", 18'(halt_detect_flag), 18'h1);
    go(8'd0, 15'h0000, 3'h0, 1'b1);
  endtask
  task automatic complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(3);
    rst <= 1'b0;
    t_fill_drain;
    t_interlock;
    t_interlace;
    t_halt;
    complete_run;
  end
  initial begin
    cyc(20000);
    n_errors++;
    complete_run;
  end
endmodule

/* srap_port_props.sv */
/*
  srap_port_props: timing checks on the port of srap_port.
  assumes it is bound to srap_port and sees only its ports.
*/
`timescale 1ns/1ps
module srap_port_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic xfer_req_n,
  input wire logic interlace_mode,
  input wire logic select_window,
  input wire logic addr_accepted,
  input wire logic late_timing_pulse,
  input wire logic request_interlock,
  input wire logic zero_count,
  input wire logic desc_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_cyc_end;
    !late_timing_pulse ##1 late_timing_pulse;
  endsequence
  sequence s_accept_run;
    (select_window && addr_accepted) [*8];
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_acc_in_win: assert property (addr_accepted |-> select_window)
    else $error("accepted outside select window");
  a_interlock_win: assert property ($rose(request_interlock)
    |-> $past(select_window) && late_timing_pulse)
    else $error("interlock rose outside an open window");
  a_late_one_low: assert property ($fell(late_timing_pulse) |-> s_cyc_end)
    else $error("late pulse low longer than one clock");
  a_late_period: assert property ($fell(late_timing_pulse) |-> ##18 $fell(late_timing_pulse))
    else $error("machine cycle not 18 clocks");
  a_win_at_start: assert property ($rose(select_window)
    |-> !$past(xfer_req_n) && !late_timing_pulse)
    else $error("window opened without request at cycle end");
  a_acc_ends_cycle: assert property ($fell(addr_accepted) |-> !late_timing_pulse)
    else $error("accepted dropped inside the cycle");
  a_acc_hold: assert property ($rose(addr_accepted) |-> s_accept_run)
    else $error("accept phase cut short");
  a_push_valid: assert property ($fell(addr_accepted) |-> desc_valid)
    else $error("descriptor not queued at cycle end");
  a_zero_stops: assert property ($fell(addr_accepted) && interlace_mode && zero_count
    |-> !select_window)
    else $error("interlace ran past zero count");
endmodule
bind srap_port srap_port_chk i_srap_port_chk (.ref_clk, .rst, .xfer_req_n, .interlace_mode,
  .select_window, .addr_accepted, .late_timing_pulse, .request_interlock, .zero_count,
  .desc_valid);

/* srap_unit_model.sv */
/*
  srap_unit_model: external unit asking for word transfers.
  assumes srap_port answers on ref_clk; start loads a new job.
*/
`timescale 1ns/1ps
module srap_unit_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        held,
  input  wire logic [7:0]  n_words,
  input  wire logic [14:0] base_addr,
  input  wire logic [2:0]  func,
  input  wire logic        select_window,
  input  wire logic        addr_accepted,
  output logic [14:0]      req_addr = 15'h0000,
  output logic [2:0]       func_code = 3'h0,
  output logic             xfer_req_n = 1'b1
);
  logic [7:0] left = 8'h00;
  logic       acc_q = 1'b0;
  always @(posedge ref_clk) acc_q <= addr_accepted;
  always @(posedge ref_clk) begin
    if (rst) begin
      left       <= 8'h00;
      xfer_req_n <= 1'b1;
    end else if (start) begin
      left       <= n_words;
      req_addr   <= base_addr;
      func_code  <= func;
      xfer_req_n <= (n_words == 8'h00);
    end else if (select_window && addr_accepted && !acc_q) begin
      left       <= left - 8'h01;
      xfer_req_n <= (left == 8'h01) || !held;
    end else if (acc_q && !addr_accepted) begin
      req_addr   <= (left != 8'h00) ? req_addr + 15'h0001 : ~req_addr;
      xfer_req_n <= (left == 8'h00);
    end
  end
endmodule
